// *** src/mtcf_pkg.sv ***
// Shared constants and types of the modulo timer core.
`default_nettype none
package mtcf_pkg;
  // Bus geometry: registers sit at byte address four times their index.
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = 6;
  localparam int          CNT_W        = 16;
  localparam int          PRESC_W      = 6;
  localparam int          DIV_W        = 3;
  // Register indices.
  localparam logic [5:0]  IDX_STATUS   = 6'h0e;
  localparam logic [5:0]  IDX_CNT_HI   = 6'h0f;
  localparam logic [5:0]  IDX_CNT_LO   = 6'h10;
  localparam logic [5:0]  IDX_PER_HI   = 6'h11;
  localparam logic [5:0]  IDX_PER_LO   = 6'h12;
  localparam logic [5:0]  IDX_CH_BASE  = 6'h13;
  // Field positions in the status/control registers.
  localparam int          BIT_FLAG     = 7;
  localparam int          BIT_IRQ_EN   = 6;
  localparam int          BIT_HALT     = 5;
  localparam int          BIT_CLEAR    = 4;
  localparam int          BIT_COMPARE  = 4;
  localparam int          DIV_LSB      = 0;
  // Clock divider code that selects the external clock pin.
  localparam logic [2:0]  DIV_EXT      = 3'h7;
  // Reset values.
  localparam logic        HALT_RST     = 1'b1;
  localparam logic [2:0]  DIV_RST      = 3'h0;
  localparam logic [15:0] PERIOD_RST   = 16'hffff;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  // Timer control fields held by software.
  typedef struct packed {
    logic       irq_en;
    logic       halt;
    logic [2:0] div;
  } mtcf_ctrl_type;

  // Per-channel control fields held by software.
  typedef struct packed {
    logic irq_en;
    logic compare;
  } mtcf_chan_type;
endpackage
`default_nettype wire

// *** src/mtcf_timer.sv ***
// Modulo timer core with overflow and channel flags behind an APB slave.
`default_nettype none
module mtcf_timer #(
  parameter int NUM_CH = 4
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  psel_i,
  input  wire logic                                  penable_i,
  input  wire logic                                  pwrite_i,
  input  wire logic [mtcf_pkg::ADDR_W-1:0]           paddr_i,
  input  wire logic [mtcf_pkg::DATA_W-1:0]           pwdata_i,
  output logic      [mtcf_pkg::DATA_W-1:0]           prdata_o,
  output logic                                       pready_o,
  output logic                                       pslverr_o,
  input  wire logic                                  wait_mode_i,
  input  wire logic                                  external_clock_pin_i,
  input  wire logic                                  clock_pin_direction_bit_i,
  input  wire logic                                  port_data_i,
  output logic                                       clock_pin_o,
  output logic                                       clock_pin_oe_o,
  input  wire logic [NUM_CH-1:0]                     channel_pin_i,
  output logic      [NUM_CH-1:0]                     channel_pin_o,
  output logic      [NUM_CH-1:0]                     channel_pin_oe_o,
  input  wire logic [NUM_CH-1:0][mtcf_pkg::CNT_W-1:0] channel_value_i,
  output logic      [mtcf_pkg::CNT_W-1:0]            count_value_o,
  output logic                                       overflow_irq_o,
  output logic      [NUM_CH-1:0]                     channel_irq_o,
  output logic                                       wake_request_o
);
  import mtcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  mtcf_ctrl_type        ctrl_reg;
  logic [CNT_W-1:0]     count_reg;
  logic [CNT_W-1:0]     period_reg;
  logic [7:0]           period_hold_reg;
  logic                 period_pending_reg;
  logic [PRESC_W-1:0]   presc_reg;
  logic                 ext_prev_reg;
  logic                 ovf_flag_reg;
  logic                 ovf_armed_reg;
  logic [7:0]           cnt_buf_reg;
  logic                 cnt_latched_reg;
  logic [DATA_W-1:0]    prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic                 overflow_irq_reg;
  logic [NUM_CH-1:0]    channel_irq_reg;
  logic                 wake_reg;
  logic                 clock_pin_reg;
  logic                 clock_pin_oe_reg;
  logic [NUM_CH-1:0]    ch_flag;
  logic [NUM_CH-1:0]    ch_irq_en;
  logic [NUM_CH-1:0]    ch_compare;
  logic [NUM_CH-1:0]    ch_event;
  logic [NUM_CH-1:0]    ch_pin_out;
  logic [IDX_W-1:0]     idx;
  logic [IDX_W-1:0]     ch_off;
  logic                 ch_hit;
  logic                 mapped;
  logic                 acc_first;
  logic                 acc_done;
  logic                 wr;
  logic                 rd_first;
  logic                 status_wr;
  logic                 clear_wr;
  logic                 ext_sel;
  logic                 ext_rise;
  logic [PRESC_W:0]     div_mask_wide;
  logic [PRESC_W-1:0]   div_mask;
  logic                 tick;
  logic                 step;
  logic                 wrap;
  logic                 ovf_event;
  logic [7:0]           rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. One wait state gives time to register the read data.
  assign idx       = paddr_i[ADDR_W-1:2];
  assign ch_off    = idx - IDX_CH_BASE;
  assign ch_hit    = (idx >= IDX_CH_BASE) && (ch_off < IDX_W'(NUM_CH));
  assign mapped    = (idx == IDX_STATUS) || (idx == IDX_CNT_HI) || (idx == IDX_CNT_LO) ||
                     (idx == IDX_PER_HI) || (idx == IDX_PER_LO) || ch_hit;
  assign acc_first = psel_i && penable_i && !pready_reg;
  assign acc_done  = psel_i && penable_i && pready_reg;
  // Wait mode shuts the CPU out, so such accesses get an error and no effect.
  assign wr        = acc_done && pwrite_i && mapped && !wait_mode_i;
  assign rd_first  = acc_first && !pwrite_i && mapped && !wait_mode_i;
  assign status_wr = wr && (idx == IDX_STATUS);
  assign clear_wr  = status_wr && pwdata_i[BIT_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock selection: prescaler taps or external pin edges.
  assign ext_sel       = (ctrl_reg.div == DIV_EXT);
  assign ext_rise      = external_clock_pin_i && !ext_prev_reg;
  assign div_mask_wide = (PRESC_W+1)'((7'h01 << ctrl_reg.div) - 7'h01);
  assign div_mask      = div_mask_wide[PRESC_W-1:0];
  // A tick every 2^div bus clocks keeps all taps aligned to one counter.
  assign tick          = ext_sel ? ext_rise : ((presc_reg & div_mask) == div_mask);
  assign step          = tick && !ctrl_reg.halt;
  assign wrap          = step && (count_reg == period_reg);
  assign ovf_event     = wrap && !period_pending_reg;

  // Prescaler; the clear bit restarts it so the first period is whole.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_reg <= '0;
    end else if (clear_wr) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + PRESC_W'(1);
    end
  end

  // Edge history of the external clock pin; the pin is already synchronous.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= external_clock_pin_i;
    end
  end

  // Counter. A clear in the same write as halt leaves it parked at zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= COUNT_RST;
    end else if (clear_wr) begin
      count_reg <= COUNT_RST;
    end else if (wrap) begin
      count_reg <= COUNT_RST;
    end else if (step) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields; the clear bit is not stored and so reads as zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg.irq_en <= 1'b0;
      ctrl_reg.halt   <= HALT_RST;
      ctrl_reg.div    <= DIV_RST;
    end else if (status_wr) begin
      ctrl_reg.irq_en <= pwdata_i[BIT_IRQ_EN];
      ctrl_reg.halt   <= pwdata_i[BIT_HALT];
      ctrl_reg.div    <= pwdata_i[DIV_LSB +: DIV_W];
    end
  end

  // Overflow flag. A fresh overflow disarms a pending clear, and wins a tie.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag_reg  <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else begin
      if (ovf_event) begin
        ovf_flag_reg  <= 1'b1;
        ovf_armed_reg <= 1'b0;
      end else if (status_wr && !pwdata_i[BIT_FLAG] && ovf_armed_reg) begin
        ovf_flag_reg  <= 1'b0;
        ovf_armed_reg <= 1'b0;
      end else if (rd_first && (idx == IDX_STATUS) && ovf_flag_reg) begin
        ovf_armed_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period: the high byte waits in a holding byte until the low byte lands.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_reg         <= PERIOD_RST;
      period_hold_reg    <= PERIOD_RST[15:8];
      period_pending_reg <= 1'b0;
    end else if (wr && (idx == IDX_PER_HI)) begin
      period_hold_reg    <= pwdata_i[7:0];
      period_pending_reg <= 1'b1;
    end else if (wr && (idx == IDX_PER_LO)) begin
      period_reg         <= {period_hold_reg, pwdata_i[7:0]};
      period_pending_reg <= 1'b0;
    end
  end

  // Coherent counter read; a forgotten low read keeps the old byte latched.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_buf_reg     <= BYTE_ZERO;
      cnt_latched_reg <= 1'b0;
    end else if (clear_wr) begin
      cnt_buf_reg     <= BYTE_ZERO;
      cnt_latched_reg <= 1'b0;
    end else if (rd_first && (idx == IDX_CNT_HI) && !cnt_latched_reg) begin
      cnt_buf_reg     <= count_reg[7:0];
      cnt_latched_reg <= 1'b1;
    end else if (rd_first && (idx == IDX_CNT_LO)) begin
      cnt_latched_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels: capture on rising pin edges or compare against the value.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    mtcf_chan_type cfg_reg;
    logic          flag_reg;
    logic          armed_reg;
    logic          pin_prev_reg;
    logic          pin_out_reg;
    logic          sel_wr;
    logic          cap_ev;
    logic          cmp_ev;

    assign sel_wr = wr && ch_hit && (ch_off == IDX_W'(i));
    // Halting the counter also blocks captures so stamps stay meaningful.
    assign cap_ev = !cfg_reg.compare && !ctrl_reg.halt &&
                    channel_pin_i[i] && !pin_prev_reg;
    assign cmp_ev = cfg_reg.compare && step && (count_reg == channel_value_i[i]);
    assign ch_event[i]   = cap_ev || cmp_ev;
    assign ch_flag[i]    = flag_reg;
    assign ch_irq_en[i]  = cfg_reg.irq_en;
    assign ch_compare[i] = cfg_reg.compare;
    assign ch_pin_out[i] = pin_out_reg;

    // Channel configuration.
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        cfg_reg <= '0;
      end else if (sel_wr) begin
        cfg_reg.irq_en  <= pwdata_i[BIT_IRQ_EN];
        cfg_reg.compare <= pwdata_i[BIT_COMPARE];
      end
    end

    // Event flag with the same read-then-write clear as the overflow flag.
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        flag_reg  <= 1'b0;
        armed_reg <= 1'b0;
      end else if (ch_event[i]) begin
        flag_reg  <= 1'b1;
        armed_reg <= 1'b0;
      end else if (sel_wr && !pwdata_i[BIT_FLAG] && armed_reg) begin
        flag_reg  <= 1'b0;
        armed_reg <= 1'b0;
      end else if (rd_first && ch_hit && (ch_off == IDX_W'(i)) && flag_reg) begin
        armed_reg <= 1'b1;
      end
    end

    // Pin history and compare output, which toggles on each match.
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        pin_prev_reg <= 1'b0;
        pin_out_reg  <= 1'b0;
      end else begin
        pin_prev_reg <= channel_pin_i[i];
        if (cmp_ev) begin
          pin_out_reg <= !pin_out_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux for the byte registers; upper bits read as zero.
  always_comb begin
    rd_byte = BYTE_ZERO;
    if (idx == IDX_STATUS) begin
      rd_byte = {ovf_flag_reg, ctrl_reg.irq_en, ctrl_reg.halt, 1'b0, 1'b0, ctrl_reg.div};
    end else if (idx == IDX_CNT_HI) begin
      rd_byte = count_reg[15:8];
    end else if (idx == IDX_CNT_LO) begin
      rd_byte = cnt_latched_reg ? cnt_buf_reg : count_reg[7:0];
    end else if (idx == IDX_PER_HI) begin
      rd_byte = period_reg[15:8];
    end else if (idx == IDX_PER_LO) begin
      rd_byte = period_reg[7:0];
    end else if (ch_hit) begin
      rd_byte = {ch_flag[ch_off[1:0]], ch_irq_en[ch_off[1:0]], 1'b0,
                 ch_compare[ch_off[1:0]], 4'h0};
    end
  end

  // APB answer: ready one cycle into the access phase, error if unmapped.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= acc_first;
      pslverr_reg <= acc_first && (!mapped || wait_mode_i);
      if (rd_first) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests and the wake request, one register stage each.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overflow_irq_reg <= 1'b0;
      channel_irq_reg  <= '0;
      wake_reg         <= 1'b0;
    end else begin
      overflow_irq_reg <= ovf_flag_reg && ctrl_reg.irq_en;
      channel_irq_reg  <= ch_flag & ch_irq_en;
      wake_reg         <= (ovf_flag_reg && ctrl_reg.irq_en) || |(ch_flag & ch_irq_en);
    end
  end

  // Clock pin port control: the direction bit loses while the pin clocks us.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_pin_reg    <= 1'b0;
      clock_pin_oe_reg <= 1'b0;
    end else begin
      clock_pin_reg    <= port_data_i;
      clock_pin_oe_reg <= clock_pin_direction_bit_i && !ext_sel;
    end
  end

  assign prdata_o         = prdata_reg;
  assign pready_o         = pready_reg;
  assign pslverr_o        = pslverr_reg;
  assign clock_pin_o      = clock_pin_reg;
  assign clock_pin_oe_o   = clock_pin_oe_reg;
  assign channel_pin_o    = ch_pin_out;
  assign channel_pin_oe_o = ch_compare;
  assign count_value_o    = count_reg;
  assign overflow_irq_o   = overflow_irq_reg;
  assign channel_irq_o    = channel_irq_reg;
  assign wake_request_o   = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ovf_flag_set: assert property (ovf_event |=> ovf_flag_reg)
    else $error("overflow flag not set after overflow");
  a_wrap_to_zero: assert property (wrap && !clear_wr |=> count_reg == 16'h0000)
    else $error("counter did not restart at zero");
  a_flag_one_ignored: assert property (status_wr && pwdata_i[BIT_FLAG] && ovf_flag_reg
                                       |=> ovf_flag_reg)
    else $error("writing one cleared the overflow flag");
  a_irq_gate: assert property (overflow_irq_o == $past(ovf_flag_reg && ctrl_reg.irq_en))
    else $error("overflow interrupt not gated by its enable");
  a_halt_holds: assert property (ctrl_reg.halt && !clear_wr |=> $stable(count_reg))
    else $error("counter moved while halted");
  a_no_capture: assert property (ctrl_reg.halt |-> (ch_event & ~ch_compare) == '0)
    else $error("capture while halted");
  a_clear_zeroes: assert property (clear_wr |=> count_reg == 16'h0000 && presc_reg == '0)
    else $error("clear did not zero counter and prescaler");
  a_halt_clear: assert property (clear_wr && pwdata_i[BIT_HALT]
                                 |=> (count_reg == 16'h0000) [*2])
    else $error("halt with clear did not park at zero");
  a_cnt_latch: assert property (rd_first && idx == IDX_CNT_HI && !cnt_latched_reg
                                && !clear_wr |=> cnt_buf_reg == $past(count_reg[7:0]))
    else $error("low byte not latched by high read");
  a_period_hold: assert property ($rose(ovf_flag_reg) |-> $past(!period_pending_reg))
    else $error("overflow flagged during period update");
  a_wake_req: assert property (|channel_irq_o |-> wake_request_o)
    else $error("channel interrupt without wake request");

  c_overflow: cover property (ovf_event ##1 overflow_irq_o);
  c_ovf_clear: cover property (ovf_flag_reg ##1 !ovf_flag_reg);
  c_chan_event: cover property (|ch_event);
  c_coherent: cover property (cnt_latched_reg && rd_first && idx == IDX_CNT_LO);
endmodule
`default_nettype wire

// *** test/modulo_timer_core_with_flags_tb.sv ***
// Self-checking bench of the modulo timer core.
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module modulo_timer_core_with_flags_tb import mtcf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             psel_i = 1'b0;
  logic             pen_i = 1'b0;
  logic             pwr_i = 1'b0;
  logic [7:0]       addr_i = 8'h00;
  logic [31:0]      wd_i = 32'h0;
  logic             wm_i = 1'b0;
  logic             ext_i = 1'b0;
  logic [3:0]       cin_i = 4'h0;
  logic [3:0][15:0] cval_i = '0;
  logic             pdir_i = 1'b1;
  logic             pdat_i = 1'b1;
  logic             pin_o;
  logic [31:0]      rd_o;
  logic             rdy_o, err_o, ovf_o, wake_o, poe_o;
  logic [3:0]       cout_o, coe_o, cirq_o;
  logic [15:0]      cnt_o;
  int               miscompares = 0;
  int               compares = 0;

  mtcf_timer #(.NUM_CH(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(pen_i), .pwrite_i(pwr_i), .paddr_i(addr_i), .pwdata_i(wd_i),
    .prdata_o(rd_o), .pready_o(rdy_o), .pslverr_o(err_o), .wait_mode_i(wm_i),
    .external_clock_pin_i(ext_i), .clock_pin_direction_bit_i(pdir_i), .port_data_i(pdat_i),
    .clock_pin_o(pin_o), .clock_pin_oe_o(poe_o), .channel_pin_i(cin_i), .channel_pin_o(cout_o),
    .channel_pin_oe_o(coe_o), .channel_value_i(cval_i), .count_value_o(cnt_o),
    .overflow_irq_o(ovf_o), .channel_irq_o(cirq_o), .wake_request_o(wake_o));

  // Free-running bus clock, 40 ns period.
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwr_i  <= w;
    addr_i <= {i, 2'b00};
    wd_i   <= {24'h000000, d};
    @(posedge clk_i);
    pen_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rdy_o !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = rd_o[7:0];
    e = err_o;
    psel_i <= 1'b0;
    pen_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    apb(1'b1, i, d, q, e);
  endtask
  task automatic rchk(input logic [5:0] i, input logic [7:0] x);
    logic [7:0] q;
    logic       e;
    apb(1'b0, i, 8'h00, q, e);
    `CHK("read data", x, q)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] q;
    logic       e;
    rchk(IDX_STATUS, 8'h20);
    rchk(IDX_CNT_HI, BYTE_ZERO);
    rchk(IDX_CNT_LO, BYTE_ZERO);
    rchk(IDX_PER_LO, 8'hff);
    rchk(IDX_CH_BASE, BYTE_ZERO);
    apb(1'b0, 6'h3f, 8'h00, q, e);
    `CHK("unmapped error", 1'b1, e)
    wr(IDX_CNT_HI, 8'h55);
    rchk(IDX_CNT_HI, BYTE_ZERO);
  endtask
  task automatic t_overflow();
    logic [15:0] p;
    logic        bad;
    logic        irq;
    bad = 1'b0;
    irq = 1'b0;
    wr(IDX_STATUS, 8'h30);
    wr(IDX_PER_HI, 8'h00);
    wr(IDX_PER_LO, 8'h03);
    wr(IDX_STATUS, 8'h40);
    p = cnt_o;
    // Every change must be a step by one or the wrap after the period.
    repeat (40) begin
      @(posedge clk_i);
      if (cnt_o !== p && cnt_o !== ((p == 16'h0003) ? 16'h0000 : p + 16'h0001)) bad = 1'b1;
      if (cnt_o > 16'h0003) bad = 1'b1;
      irq = irq | ovf_o;
      p = cnt_o;
    end
    `CHK("count sequence", 1'b0, bad)
    `CHK("overflow request", 1'b1, irq)
    wr(IDX_STATUS, 8'h20);
    cyc(2);
    `CHK("masked request", 1'b0, ovf_o)
    rchk(IDX_STATUS, 8'ha0);
    wr(IDX_STATUS, 8'he0);
    rchk(IDX_STATUS, 8'he0);
    `CHK("enabled request", 1'b1, ovf_o)
    wr(IDX_STATUS, 8'h60);
    rchk(IDX_STATUS, 8'h60);
    `CHK("cleared request", 1'b0, ovf_o)
  endtask
  task automatic t_race();
    wr(IDX_STATUS, 8'h40);
    cyc(8);
    rchk(IDX_STATUS, 8'hc0);
    cyc(8);
    wr(IDX_STATUS, 8'h60);
    rchk(IDX_STATUS, 8'he0);
    wr(IDX_STATUS, 8'h60);
    rchk(IDX_STATUS, 8'h60);
  endtask
  task automatic t_clear();
    wr(IDX_STATUS, 8'h30);
    wr(IDX_PER_HI, 8'h12);
    wr(IDX_PER_LO, 8'h34);
    wr(IDX_STATUS, 8'h00);
    cyc(20);
    wr(IDX_STATUS, 8'h10);
    `CHK("restart from zero", 1'b1, cnt_o < 16'h0004)
    cyc(20);
    wr(IDX_STATUS, 8'h30);
    cyc(5);
    `CHK("stopped at zero", 16'h0000, cnt_o)
    rchk(IDX_CNT_HI, BYTE_ZERO);
    rchk(IDX_CNT_LO, BYTE_ZERO);
    rchk(IDX_STATUS, 8'h20);
    rchk(IDX_PER_LO, 8'h34);
  endtask
  task automatic t_latch();
    logic [15:0] x;
    logic [7:0]  q;
    logic        e;
    wr(IDX_STATUS, 8'h00);
    cyc(300);
    wr(IDX_STATUS, 8'h20);
    x = cnt_o;
    cyc(4);
    `CHK("held count", x, cnt_o)
    apb(1'b0, IDX_CNT_HI, 8'h00, q, e);
    `CHK("count high", x[15:8], q)
    wr(IDX_STATUS, 8'h00);
    cyc(100);
    wr(IDX_STATUS, 8'h20);
    apb(1'b0, IDX_CNT_HI, 8'h00, q, e);
    rchk(IDX_CNT_LO, x[7:0]);
  endtask
  // About 260 bus clocks pass between start and stop, whatever the divider.
  task automatic t_div();
    logic ok;
    for (int d = 0; d < 7; d++) begin
      wr(IDX_STATUS, 8'h30 | 8'(d));
      wr(IDX_STATUS, 8'(d));
      cyc(256);
      wr(IDX_STATUS, 8'h20 | 8'(d));
      ok = (cnt_o >= (16'h0100 >> d)) && (cnt_o <= (16'h0108 >> d) + 16'h0001);
      `CHK("divided count", 1'b1, ok)
    end
  endtask
  task automatic t_ext();
    pdat_i <= 1'b0;
    wr(IDX_STATUS, 8'h30);
    cyc(2);
    `CHK("pin drive", 1'b1, poe_o)
    `CHK("pin data", 1'b0, pin_o)
    // With the bus clock selected the direction bit alone steers the pin.
    pdir_i <= 1'b0;
    cyc(2);
    `CHK("pin released", 1'b0, poe_o)
    pdir_i <= 1'b1;
    wr(IDX_STATUS, 8'h37);
    wr(IDX_STATUS, 8'h07);
    cyc(2);
    `CHK("pin drive", 1'b0, poe_o)
    // Eight bus clocks per pulse keeps the pin at 3.125 MHz.
    repeat (5) begin
      ext_i <= 1'b1;
      cyc(4);
      ext_i <= 1'b0;
      cyc(4);
    end
    `CHK("external ticks", 16'h0005, cnt_o)
    wr(IDX_STATUS, 8'h20);
  endtask
  task automatic t_chan();
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CH_BASE + 6'(c), 8'h40);
      rchk(IDX_CH_BASE + 6'(c), 8'h40);
      for (int k = 0; k < 2; k++) begin
        cin_i[c] <= 1'b1;
        cyc(2);
        cin_i[c] <= 1'b0;
        cyc(3);
        if (k == 0) rchk(IDX_CH_BASE + 6'(c), 8'h40);
        if (k == 0) wr(IDX_STATUS, 8'h00);
      end
      `CHK("channel requests", 4'h1 << c, cirq_o)
      rchk(IDX_CH_BASE + 6'(c), 8'hc0);
      wr(IDX_CH_BASE + 6'(c), 8'hc0);
      rchk(IDX_CH_BASE + 6'(c), 8'hc0);
      wr(IDX_CH_BASE + 6'(c), 8'h00);
      rchk(IDX_CH_BASE + 6'(c), 8'h00);
      `CHK("capture drive", 1'b0, coe_o[c])
      wr(IDX_STATUS, 8'h20);
    end
    cval_i[2] <= 16'h0010;
    wr(IDX_STATUS, 8'h30);
    wr(IDX_CH_BASE + 6'h02, 8'h50);
    wr(IDX_STATUS, 8'h00);
    cyc(40);
    wr(IDX_STATUS, 8'h20);
    `CHK("compare drive", 4'h4, coe_o)
    `CHK("compare output", 4'h4, cout_o)
    `CHK("compare request", 4'h4, cirq_o)
    rchk(IDX_CH_BASE + 6'h02, 8'hd0);
    wr(IDX_CH_BASE + 6'h02, 8'h00);
  endtask
  task automatic t_wait();
    logic [7:0] q;
    logic       e;
    wr(IDX_STATUS, 8'h30);
    wr(IDX_PER_HI, 8'h00);
    wr(IDX_PER_LO, 8'h03);
    `CHK("quiet wake", 1'b0, wake_o)
    // The timer is left running into wait so that its overflow can wake.
    wr(IDX_STATUS, 8'h40);
    wm_i <= 1'b1;
    apb(1'b1, IDX_STATUS, 8'h20, q, e);
    `CHK("refused access", 1'b1, e)
    cyc(6);
    `CHK("wake request", 1'b1, wake_o)
    wm_i <= 1'b0;
    rchk(IDX_STATUS, 8'hc0);
  endtask
  task automatic t_susp();
    wr(IDX_STATUS, 8'h30);
    rchk(IDX_STATUS, 8'ha0);
    wr(IDX_STATUS, 8'h20);
    wr(IDX_PER_HI, 8'h00);
    wr(IDX_STATUS, 8'h00);
    cyc(30);
    rchk(IDX_STATUS, 8'h00);
    wr(IDX_PER_LO, 8'h03);
    cyc(10);
    rchk(IDX_STATUS, 8'h80);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence: reset for eight clocks, then every scenario in turn.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_overflow();
    t_race();
    t_clear();
    t_latch();
    t_div();
    t_ext();
    t_chan();
    t_wait();
    t_susp();
    complete_run();
  end
  // The scenarios need under 5000 clocks, so this limit only trips on a hang.
  initial begin
    cyc(20000);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
